/* File: common/brtx_pkg.sv */
// Package with widths, reset values and FIFO sizing for the transceiver
package brtx_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [7:0]  REG_RESET  = 8'h00;
    localparam logic [1:0]  EDGE_RISE  = 2'h1;
    typedef logic [DATA_W-1:0] brtx_byte_t;
endpackage

/* File: rtl/brtx_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module brtx_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ==========================================================
    // Checks
    fifo_no_overflow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
endmodule

/* File: rtl/brtx_top.sv */
// Registered bidirectional octal transceiver core
// How it works
// - Two 8-bit registers, one per direction; each pin feeds one
// - Each direction has its own clock, sampled as a rising-edge event
// - Each direction's active-low load enable gates only its own register
// - On clock rise with load enable low, source pins are stored
// - With load enable high the register holds whatever clock or data do
// - Far-side pins drive stored contents only while drive enable is low
// - Drive enable high puts all eight drivers of that side off
// - B-to-A path behaves as A-to-B with sides swapped
// - A side that drives its own pins reads their last level from a keeper copy
`timescale 1ns/1ns
module brtx_top
    import brtx_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire logic                        clk_a_to_b,
    input  wire logic                        clk_b_to_a,
    input  wire logic                        load_en_n_a_to_b,
    input  wire logic                        load_en_n_b_to_a,
    input  wire logic                        drive_en_n_b_side,
    input  wire logic                        drive_en_n_a_side,
    input  wire logic [brtx_pkg::DATA_W-1:0] side_a_pins_i,
    output logic      [brtx_pkg::DATA_W-1:0] side_a_pins_o,
    output logic      [brtx_pkg::DATA_W-1:0] side_a_pins_oe,
    input  wire logic [brtx_pkg::DATA_W-1:0] side_b_pins_i,
    output logic      [brtx_pkg::DATA_W-1:0] side_b_pins_o,
    output logic      [brtx_pkg::DATA_W-1:0] side_b_pins_oe,
    output logic                             cap_valid,
    input  wire logic                        cap_ready,
    output logic      [brtx_pkg::DATA_W-1:0] cap_data,
    output logic                             cap_stall
);
    import brtx_pkg::*;

    // ==========================================================
    // Direction clock edge detection
    // Direction clocks are sampled on ref_clk; they must be slower
    // than half the system rate so every rise is seen.
    // One earlier sample is all the rise detector needs
    logic        ab_clk_hist_q;
    logic        ba_clk_hist_q;
    logic        ab_rise;
    logic        ba_rise;
    logic        ab_load;
    logic        ba_load;
    brtx_byte_t  ab_q;
    brtx_byte_t  ba_q;
    brtx_byte_t  a_keep_q;
    brtx_byte_t  b_keep_q;
    brtx_byte_t  a_seen;
    brtx_byte_t  b_seen;
    logic        fifo_in_ready;

    // Earlier sample low and present level high
    function automatic logic is_rise(input logic [1:0] h);
        return h == EDGE_RISE;
    endfunction

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ab_clk_hist_q <= '0;
            ba_clk_hist_q <= '0;
        end else begin
            ab_clk_hist_q <= clk_a_to_b;
            ba_clk_hist_q <= clk_b_to_a;
        end
    end

    assign ab_rise = is_rise({ab_clk_hist_q, clk_a_to_b});
    assign ba_rise = is_rise({ba_clk_hist_q, clk_b_to_a});
    // A clock rise with enable low is the load condition; a full capture FIFO does not
    // block the register, it only raises cap_stall.
    assign ab_load = ab_rise & ~load_en_n_a_to_b;
    assign ba_load = ba_rise & ~load_en_n_b_to_a;

    // ==========================================================
    // Keepers: a pin this side drives itself reads its last level from the copy
    // While a side drives its own pins the register would read back its
    // own output; the keeper copy stands in for that pin level.
    assign a_seen = (drive_en_n_a_side) ? side_a_pins_i : a_keep_q;
    assign b_seen = (drive_en_n_b_side) ? side_b_pins_i : b_keep_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_keep_q <= REG_RESET;
            b_keep_q <= REG_RESET;
        end else begin
            a_keep_q <= drive_en_n_a_side ? side_a_pins_i : ba_q;
            b_keep_q <= drive_en_n_b_side ? side_b_pins_i : ab_q;
        end
    end

    // ==========================================================
    // Direction registers
    // No else branch: with the enable high the flops keep their word,
    // so the two directions never disturb each other.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ab_q <= REG_RESET;
        end else if (ab_load) begin
            ab_q <= a_seen;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ba_q <= REG_RESET;
        end else if (ba_load) begin
            ba_q <= b_seen;
        end
    end

    // ==========================================================
    // Output drivers
    assign side_b_pins_o  = ab_q;
    assign side_a_pins_o  = ba_q;
    // Drivers stay off throughout reset, whatever the enables say
    assign side_b_pins_oe = rstn ? {DATA_W{~drive_en_n_b_side}}
                                 : '0;
    assign side_a_pins_oe = rstn ? {DATA_W{~drive_en_n_a_side}}
                                 : '0;

    // ==========================================================
    // Capture stream of each A-to-B load that finds the FIFO with room, for observation
    // Only A-to-B is streamed; B-to-A is observed on its pins alone
    brtx_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (ab_load),
        .in_ready  (fifo_in_ready),
        .in_data   (a_seen),
        .out_valid (cap_valid),
        .out_ready (cap_ready),
        .out_data  (cap_data)
    );
    assign cap_stall = ~fifo_in_ready;

    // ==========================================================
    // Checks
    // All on ref_clk; the direction clocks are only ever seen as levels
    ab_load_capt_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ab_load |=> ab_q == $past(a_seen))
        else $error("a-to-b load lost");
    ab_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        load_en_n_a_to_b |=> $stable(ab_q))
        else $error("a-to-b changed while disabled");
    ba_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (load_en_n_b_to_a || !ba_rise) |=> $stable(ba_q))
        else $error("b-to-a changed without load");
    ba_load_capt_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ba_load |=> ba_q == $past(b_seen))
        else $error("b-to-a load lost");
    b_drive_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !drive_en_n_b_side |-> side_b_pins_oe == '1 && side_b_pins_o == ab_q)
        else $error("b side not driving register");
    a_drive_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !drive_en_n_a_side |-> side_a_pins_oe == '1 && side_a_pins_o == ba_q)
        else $error("a side not driving register");
    a_off_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        drive_en_n_a_side |-> side_a_pins_oe == '0)
        else $error("a side driven while disabled");
    b_off_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        drive_en_n_b_side |-> side_b_pins_oe == '0)
        else $error("b side driven while disabled");
    reset_clear_a: assert property (
        @(posedge ref_clk)
        $rose(rstn) |-> ab_q == REG_RESET && ba_q == REG_RESET)
        else $error("registers not cleared by reset");
    reset_off_a: assert property (
        @(posedge ref_clk)
        !rstn |-> side_a_pins_oe == '0 && side_b_pins_oe == '0)
        else $error("driver on during reset");
    keep_level_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        drive_en_n_a_side ##1 drive_en_n_a_side
        |-> a_keep_q == $past(side_a_pins_i))
        else $error("keeper lost level");
    keep_level_b_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        drive_en_n_b_side ##1 drive_en_n_b_side
        |-> b_keep_q == $past(side_b_pins_i))
        else $error("b keeper lost level");
    no_load_rise_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !ab_rise |=> $stable(ab_q))
        else $error("a-to-b loaded without clock rise");
    ab_one_rise_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ab_rise |=> !ab_rise)
        else $error("a-to-b clock seen rising twice");
    ba_one_rise_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ba_rise |=> !ba_rise)
        else $error("b-to-a clock seen rising twice");
    dir_indep_ab_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ba_load && !ab_load |=> $stable(ab_q))
        else $error("b-to-a load disturbed a-to-b");
    dir_indep_ba_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ab_load && !ba_load |=> $stable(ba_q))
        else $error("a-to-b load disturbed b-to-a");
    cap_push_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ab_load && !cap_stall |=> cap_valid)
        else $error("load not queued for capture");
    cap_drop_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ab_load && cap_stall && !cap_ready |=> cap_stall)
        else $error("full capture queue took a word");
endmodule

/* File: bench/brtx_bus_model.sv */
// Behavioural model of one bus that faces a side of the transceiver
`timescale 1ns/1ns
module brtx_bus_model (
    input  wire logic               ref_clk,
    input  wire logic               ext_en,
    input  wire brtx_pkg::brtx_byte_t ext_val,
    input  wire brtx_pkg::brtx_byte_t dev_o,
    input  wire brtx_pkg::brtx_byte_t dev_oe,
    output brtx_pkg::brtx_byte_t      wire_lvl
);
    import brtx_pkg::*;
    brtx_byte_t keep_q = 8'h00;
    // Outside logic yields bitwise wherever the device drives
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            wire_lvl[i] = dev_oe[i] ? dev_o[i] :
                (ext_en ? ext_val[i] : keep_q[i]);
        end
    end
    always_ff @(posedge ref_clk) begin
        keep_q <= wire_lvl;
    end
endmodule

/* File: bench/brtx_top_tb.sv */
// Self-checking bench for the registered transceiver
`timescale 1ns/1ns
module brtx_top_tb;
    import brtx_pkg::*;
    logic ref_clk = 0, rstn = 0, cap_ready = 0, cap_valid, cap_stall;
    logic clk_a_to_b = 0, clk_b_to_a = 0, ea_en = 1, eb_en = 1;
    logic load_en_n_a_to_b = 1, load_en_n_b_to_a = 1;
    logic drive_en_n_a_side = 1, drive_en_n_b_side = 1;
    brtx_byte_t ea = 0, eb = 0, a_i, a_o, a_oe, b_i, b_o, b_oe, cap_data;
    brtx_byte_t q[$];
    int n_errors = 0, checks_done = 0, cycles = 0;
    brtx_top i_brtx_top (.ref_clk, .rstn, .clk_a_to_b, .clk_b_to_a,
        .load_en_n_a_to_b, .load_en_n_b_to_a, .drive_en_n_a_side,
        .drive_en_n_b_side, .side_a_pins_i(a_i), .side_a_pins_o(a_o),
        .side_a_pins_oe(a_oe), .side_b_pins_i(b_i), .side_b_pins_o(b_o),
        .side_b_pins_oe(b_oe), .cap_valid, .cap_ready, .cap_data, .cap_stall);
    brtx_bus_model i_brtx_bus_model_a (.ref_clk, .ext_en(ea_en),
        .ext_val(ea), .dev_o(a_o), .dev_oe(a_oe), .wire_lvl(a_i));
    brtx_bus_model i_brtx_bus_model_b (.ref_clk, .ext_en(eb_en),
        .ext_val(eb), .dev_o(b_o), .dev_oe(b_oe), .wire_lvl(b_i));
    always #5 ref_clk = ~ref_clk;
    // Cut a hang short well past the 125 or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    // One direction clock rise; ba selects the B-to-A path
    task automatic pulse(input bit ba, input brtx_byte_t v, input logic en_n);
        tick();
        ea = ba ? ea : v;
        eb = ba ? v : eb;
        load_en_n_a_to_b = ba | en_n;
        load_en_n_b_to_a = ~ba | en_n;
        {clk_a_to_b, clk_b_to_a} = {~ba, ba};
        if (!ba && !en_n && q.size() < FIFO_DEPTH) q.push_back(v);
        tick();
        {clk_a_to_b, clk_b_to_a, load_en_n_a_to_b, load_en_n_b_to_a} = 4'h3;
    endtask
    task automatic t_reset();
        check(a_oe | b_oe | a_o | b_o, 8'h00);
        check({7'h0, cap_valid}, 8'h00);
    endtask
    task automatic t_load();
        pulse(0, 8'h5a, 0);
        check(b_o, 8'h5a);
        check(b_oe, 8'h00);
        check(a_o, REG_RESET);
        drive_en_n_b_side = 0;
        ea = 8'h11;
        tick();
        check(b_oe, 8'hff);
        check(b_i, 8'h5a);
        drive_en_n_b_side = 1;
        pulse(0, 8'ha5, 1);
        check(b_o, 8'h5a);
    endtask
    task automatic t_back();
        eb = 8'h3c;
        tick();
        eb_en = 0;
        pulse(1, 8'hff, 0);
        check(a_o, 8'h3c);
        check(b_o, 8'h5a);
        {drive_en_n_a_side, drive_en_n_b_side} = 2'h0;
        tick();
        check(a_i & a_oe, 8'h3c);
        check(b_i, 8'h5a);
        {drive_en_n_a_side, drive_en_n_b_side} = 2'h3;
        eb_en = 1;
    endtask
    // A clock held high must load once only
    task automatic t_long();
        tick();
        {ea, load_en_n_a_to_b, clk_a_to_b} = {8'h77, 2'h1};
        q.push_back(8'h77);
        repeat (3) tick();
        ea = 8'h88;
        repeat (3) tick();
        check(b_o, 8'h77);
        {clk_a_to_b, load_en_n_a_to_b} = 2'h1;
    endtask
    // Fill past the FIFO depth with the reader stalled, then drain
    task automatic t_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++) pulse(0, 8'h80 + 8'(i), 0);
        check({7'h0, cap_stall}, 8'h01);
        cap_ready = 1;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            check(cap_data, q[i]);
            tick();
        end
        cap_ready = 0;
        check({7'h0, cap_valid}, 8'h00);
    endtask
    // A reset in mid-run must clear loaded registers and silence drivers
    task automatic t_rerun();
        pulse(0, 8'h42, 0);
        check(b_o, 8'h42);
        check({7'h0, cap_valid}, 8'h01);
        {drive_en_n_a_side, drive_en_n_b_side} = 2'h0;
        rstn = 0;
        tick();
        check(a_oe | b_oe | a_o | b_o, 8'h00);
        check({7'h0, cap_valid}, 8'h00);
        rstn = 1;
        tick();
        check(a_oe & b_oe, 8'hff);
        check(a_o | b_o, REG_RESET);
        {drive_en_n_a_side, drive_en_n_b_side} = 2'h3;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        t_reset();
        #1 rstn = 1;
        t_load();
        t_back();
        t_long();
        t_fifo();
        t_rerun();
        complete_run();
    end
endmodule
